// >>> logic/cofd_map.svh
`ifndef COFD_MAP_SVH
`define COFD_MAP_SVH
`define COFD_WORD_W      16
`define COFD_ACC_W       36
`define COFD_SHAMT_W     4
`define COFD_MASK_ALL    16'hFFFF
`define COFD_ZERO_WORD   16'h0000
`define COFD_ZERO_ACC    36'h0_0000_0000
`define COFD_SP_RESET    16'h0000
`define COFD_OSC_PER_IC  2
`define COFD_ACC_HI_LSB  16
`define COFD_ACC_HI_MSB  31
`endif

// >>> logic/cofd_pkg.sv
package cofd_pkg;
  // operation codes presented to the decoder
  typedef enum logic [3:0] {
    COFD_OP_NOP      = 4'b0000,
    COFD_OP_AND_IMM  = 4'b0001,
    COFD_OP_OR_IMM   = 4'b0010,
    COFD_OP_XOR_IMM  = 4'b0011,
    COFD_OP_NOT      = 4'b0100,
    COFD_OP_BF_CLR   = 4'b0101,
    COFD_OP_BF_SET   = 4'b0110,
    COFD_OP_BF_TGL   = 4'b0111,
    COFD_OP_MULTIBIT_LOGICAL_SHIFT     = 4'b1000,
    COFD_OP_MULTIBIT_ARITH_SHIFT     = 4'b1001,
    COFD_OP_ASL1     = 4'b1010,
    COFD_OP_ZERO     = 4'b1011,
    COFD_OP_PULL     = 4'b1100,
    COFD_OP_PULL_NONE = 4'b1101
  } cofd_op_t;
  // register identifiers
  typedef enum logic [3:0] {
    COFD_R_A  = 4'b0000,
    COFD_R_B  = 4'b0001,
    COFD_R_A1 = 4'b0010,
    COFD_R_B1 = 4'b0011,
    COFD_R_X0 = 4'b0100,
    COFD_R_Y0 = 4'b0101,
    COFD_R_Y1 = 4'b0110,
    COFD_R_R0 = 4'b0111,
    COFD_R_R1 = 4'b1000,
    COFD_R_R2 = 4'b1001,
    COFD_R_R3 = 4'b1010,
    COFD_R_N  = 4'b1011,
    COFD_R_SP = 4'b1100,
    COFD_R_M  = 4'b1101,
    COFD_R_MEM = 4'b1110
  } cofd_reg_t;
  // executed core operation after alias remapping
  typedef enum logic [2:0] {
    COFD_EX_NONE  = 3'b000,
    COFD_EX_BITFIELD_CLEAR_TEST = 3'b001,
    COFD_EX_BITFIELD_SET_TEST = 3'b010,
    COFD_EX_BFTGL = 3'b011,
    COFD_EX_MULTIBIT_ARITH_SHIFT  = 3'b100,
    COFD_EX_LSL1  = 3'b101,
    COFD_EX_ASL1  = 3'b110,
    COFD_EX_MOVE  = 3'b111
  } cofd_ex_t;
  // operand field sets
  typedef enum logic [3:0] {
    COFD_SET_DATA   = 4'b0000,
    COFD_SET_EXT    = 4'b0001,
    COFD_SET_PTRSP  = 4'b0010,
    COFD_SET_PTR    = 4'b0011,
    COFD_SET_IDX    = 4'b0100,
    COFD_SET_MOD    = 4'b0101,
    COFD_SET_ARITH  = 4'b0110,
    COFD_SET_UPPER  = 4'b0111,
    COFD_SET_DD     = 4'b1000,
    COFD_SET_ACC    = 4'b1001,
    COFD_SET_ACCHI  = 4'b1010
  } cofd_set_t;
endpackage

// >>> logic/cofd_field_check.sv
`timescale 1ns/1ps
`include "cofd_map.svh"
// operand set membership for one register
module cofd_field_check (
  input  wire cofd_pkg::cofd_set_t set_i,
  input  wire cofd_pkg::cofd_reg_t reg_i,
  output logic                     member_o
);
  import cofd_pkg::*;
  function automatic logic is_dd(input cofd_reg_t r);
    is_dd = (r == COFD_R_X0) || (r == COFD_R_Y0) || (r == COFD_R_Y1);
  endfunction
  function automatic logic is_acc(input cofd_reg_t r);
    is_acc = (r == COFD_R_A) || (r == COFD_R_B);
  endfunction
  function automatic logic is_hi(input cofd_reg_t r);
    is_hi = (r == COFD_R_A1) || (r == COFD_R_B1);
  endfunction
  function automatic logic is_ptr(input cofd_reg_t r);
    is_ptr = (r == COFD_R_R0) || (r == COFD_R_R1) || (r == COFD_R_R2) || (r == COFD_R_R3);
  endfunction
  // set decode
  always_comb begin
    case (set_i)
      COFD_SET_DATA:  member_o = is_acc(reg_i) || is_hi(reg_i) || is_dd(reg_i);
      COFD_SET_EXT:   member_o = is_acc(reg_i) || is_hi(reg_i) || is_dd(reg_i)
                                 || is_ptr(reg_i) || (reg_i == COFD_R_N);
      COFD_SET_PTRSP: member_o = is_ptr(reg_i) || (reg_i == COFD_R_SP);
      COFD_SET_PTR:   member_o = is_ptr(reg_i);
      COFD_SET_IDX:   member_o = (reg_i == COFD_R_N);
      COFD_SET_MOD:   member_o = (reg_i == COFD_R_M);
      COFD_SET_ARITH: member_o = is_acc(reg_i) || is_dd(reg_i);
      COFD_SET_UPPER: member_o = is_hi(reg_i) || is_dd(reg_i);
      COFD_SET_DD:    member_o = is_dd(reg_i);
      COFD_SET_ACC:   member_o = is_acc(reg_i);
      COFD_SET_ACCHI: member_o = is_hi(reg_i);
      default:        member_o = 1'b0;
    endcase
  end
endmodule

// >>> logic/cofd_decode.sv
`timescale 1ns/1ps
`include "cofd_map.svh"
module cofd_decode #(
  parameter int OSC_PER_IC = `COFD_OSC_PER_IC
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   insn_valid_i,
  input  wire cofd_pkg::cofd_op_t     op_i,
  input  wire cofd_pkg::cofd_reg_t    dst_i,
  input  wire cofd_pkg::cofd_reg_t    src1_i,
  input  wire cofd_pkg::cofd_reg_t    src2_i,
  input  wire logic [15:0]            imm_i,
  input  wire logic [15:0]            dst_val_i,
  input  wire logic [15:0]            src1_val_i,
  input  wire logic [15:0]            src2_val_i,
  input  wire logic [15:0]            mem_rdata_i,
  input  wire logic                   acc_sat_sel_i,
  input  wire cofd_pkg::cofd_set_t    chk_set_i,
  input  wire cofd_pkg::cofd_reg_t    chk_reg_i,
  output logic                        ic_en_o,
  output logic                        busy_o,
  output logic                        done_o,
  output cofd_pkg::cofd_ex_t          ex_op_o,
  output logic                        illegal_o,
  output cofd_pkg::cofd_reg_t         wr_reg_o,
  output logic                        wr_en_o,
  output logic [15:0]                 wr_data_o,
  output logic                        acc_clr_o,
  output logic                        cc_upd_o,
  output logic                        cc_logic_o,
  output logic                        bf_all_o,
  output logic [15:0]                 mem_addr_o,
  output logic                        mem_rd_o,
  output logic [15:0]                 sp_o,
  output logic                        acc_sat_o,
  output logic                        chk_member_o
);
  import cofd_pkg::*;

  typedef enum logic [1:0] {
    COFD_ST_IDLE = 2'b00,
    COFD_ST_EXEC = 2'b01,
    COFD_ST_PULL = 2'b10
  } cofd_state_t;

  cofd_state_t state_q;
  logic [3:0]  osc_cnt_q;
  logic        ic_tick;
  cofd_op_t    op_q;
  cofd_reg_t   dst_q;
  cofd_reg_t   src1_q;
  cofd_reg_t   src2_q;
  logic [15:0] imm_q;
  logic [15:0] dval_q;
  logic [15:0] s1val_q;
  logic [15:0] s2val_q;
  logic        sat_q;
  logic [15:0] sp_q;
  logic        member;

  // register class helpers
  function automatic logic is_dd(input cofd_reg_t r);
    is_dd = (r == COFD_R_X0) || (r == COFD_R_Y0) || (r == COFD_R_Y1);
  endfunction
  function automatic logic is_acc(input cofd_reg_t r);
    is_acc = (r == COFD_R_A) || (r == COFD_R_B);
  endfunction
  // every 16-bit register that a zero move may name
  function automatic logic is_word16(input cofd_reg_t r);
    is_word16 = is_dd(r) || (r == COFD_R_A1) || (r == COFD_R_B1) || (r == COFD_R_R0)
                || (r == COFD_R_R1) || (r == COFD_R_R2) || (r == COFD_R_R3) || (r == COFD_R_N);
  endfunction
  // multi-bit shift operand pair check
  function automatic logic shift_pair_ok(input cofd_reg_t v, input cofd_reg_t a, input cofd_reg_t d);
    logic pair;
    pair = ((v == COFD_R_Y1) && (a == COFD_R_X0)) || ((v == COFD_R_Y0) && (a == COFD_R_X0))
        || ((v == COFD_R_Y1) && (a == COFD_R_Y0)) || ((v == COFD_R_Y0) && (a == COFD_R_Y0))
        || ((v == COFD_R_A1) && (a == COFD_R_Y0)) || ((v == COFD_R_B1) && (a == COFD_R_Y1));
    shift_pair_ok = pair && is_dd(d);
  endfunction
  // bit-field destinations: 16-bit registers or a data memory word
  function automatic logic bf_dst_ok(input cofd_reg_t d);
    bf_dst_ok = is_word16(d) || (d == COFD_R_MEM) || (d == COFD_R_SP) || (d == COFD_R_M);
  endfunction

  // operand set membership lookup
  cofd_field_check u_field (
    .set_i    (chk_set_i),
    .reg_i    (chk_reg_i),
    .member_o (member)
  );

  // instruction cycle enable from oscillator divider
  assign ic_tick = (osc_cnt_q == 4'(OSC_PER_IC - 1));
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_cnt_q <= 4'h0;
    end else if (ic_tick) begin
      osc_cnt_q <= 4'h0;
    end else begin
      osc_cnt_q <= osc_cnt_q + 4'h1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ic_en_o <= 1'b0;
    end else begin
      ic_en_o <= ic_tick;
    end
  end

  // instruction capture
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_q    <= COFD_OP_NOP;
      dst_q   <= COFD_R_A;
      src1_q  <= COFD_R_A;
      src2_q  <= COFD_R_A;
      imm_q   <= `COFD_ZERO_WORD;
      dval_q  <= `COFD_ZERO_WORD;
      s1val_q <= `COFD_ZERO_WORD;
      s2val_q <= `COFD_ZERO_WORD;
      sat_q   <= 1'b0;
    end else if (state_q == COFD_ST_IDLE && insn_valid_i && ic_tick) begin
      op_q    <= op_i;
      dst_q   <= dst_i;
      src1_q  <= src1_i;
      src2_q  <= src2_i;
      imm_q   <= imm_i;
      dval_q  <= dst_val_i;
      s1val_q <= src1_val_i;
      s2val_q <= src2_val_i;
      sat_q   <= acc_sat_sel_i;
    end
  end

  // sequencer: exec on one instruction cycle, a named pull adds a memory cycle
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= COFD_ST_IDLE;
    end else if (ic_tick) begin
      case (state_q)
        COFD_ST_IDLE: begin
          if (insn_valid_i) begin
            state_q <= (op_i == COFD_OP_PULL) ? COFD_ST_PULL : COFD_ST_EXEC;
          end
        end
        COFD_ST_PULL: state_q <= COFD_ST_EXEC;
        COFD_ST_EXEC: state_q <= COFD_ST_IDLE;
        default:      state_q <= COFD_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_q != COFD_ST_IDLE);
    end
  end

  // memory read request for stack pull
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_rd_o   <= 1'b0;
      mem_addr_o <= `COFD_ZERO_WORD;
    end else begin
      mem_rd_o   <= (state_q == COFD_ST_PULL) && ic_tick;
      mem_addr_o <= sp_q;
    end
  end

  // stack pointer decrement after pull
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_q <= `COFD_SP_RESET;
    end else if (state_q == COFD_ST_EXEC && ic_tick
                 && (op_q == COFD_OP_PULL || op_q == COFD_OP_PULL_NONE)) begin
      sp_q <= sp_q - 16'h0001;
    end
  end
  assign sp_o = sp_q;

  // execution and write-back
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o     <= 1'b0;
      ex_op_o    <= COFD_EX_NONE;
      illegal_o  <= 1'b0;
      wr_reg_o   <= COFD_R_A;
      wr_en_o    <= 1'b0;
      wr_data_o  <= `COFD_ZERO_WORD;
      acc_clr_o  <= 1'b0;
      cc_upd_o   <= 1'b0;
      cc_logic_o <= 1'b0;
      bf_all_o   <= 1'b0;
      acc_sat_o  <= 1'b0;
    end else if (state_q == COFD_ST_EXEC && ic_tick) begin
      done_o     <= 1'b1;
      wr_reg_o   <= dst_q;
      wr_en_o    <= 1'b0;
      acc_clr_o  <= 1'b0;
      cc_upd_o   <= 1'b0;
      cc_logic_o <= 1'b0;
      illegal_o  <= 1'b0;
      bf_all_o   <= 1'b0;
      acc_sat_o  <= sat_q;
      ex_op_o    <= COFD_EX_NONE;
      wr_data_o  <= `COFD_ZERO_WORD;
      case (op_q)
        // immediate logic only via bit-field ops, unmasked bits kept
        COFD_OP_AND_IMM, COFD_OP_BF_CLR: begin
          ex_op_o   <= COFD_EX_BITFIELD_CLEAR_TEST;
          illegal_o <= !bf_dst_ok(dst_q);
          wr_en_o   <= bf_dst_ok(dst_q);
          cc_upd_o  <= 1'b1;
          if (op_q == COFD_OP_AND_IMM) begin
            wr_data_o <= dval_q & imm_q;
            bf_all_o  <= ((dval_q & ~imm_q) == ~imm_q);
          end else begin
            wr_data_o <= dval_q & ~imm_q;
            bf_all_o  <= ((dval_q & imm_q) == imm_q);
          end
        end
        // or-immediate maps onto bit-field set
        COFD_OP_OR_IMM, COFD_OP_BF_SET: begin
          ex_op_o   <= COFD_EX_BITFIELD_SET_TEST;
          illegal_o <= !bf_dst_ok(dst_q);
          wr_en_o   <= bf_dst_ok(dst_q);
          cc_upd_o  <= 1'b1;
          wr_data_o <= dval_q | imm_q;
          bf_all_o  <= ((dval_q & imm_q) == imm_q);
        end
        // xor-immediate maps onto bit-field toggle
        COFD_OP_XOR_IMM, COFD_OP_BF_TGL: begin
          ex_op_o   <= COFD_EX_BFTGL;
          illegal_o <= !bf_dst_ok(dst_q);
          wr_en_o   <= bf_dst_ok(dst_q);
          cc_upd_o  <= 1'b1;
          wr_data_o <= dval_q ^ imm_q;
          bf_all_o  <= ((dval_q & imm_q) == imm_q);
        end
        // complement: toggle with every mask bit set
        COFD_OP_NOT: begin
          ex_op_o   <= COFD_EX_BFTGL;
          illegal_o <= !bf_dst_ok(dst_q);
          wr_en_o   <= bf_dst_ok(dst_q);
          cc_upd_o  <= 1'b1;
          wr_data_o <= dval_q ^ `COFD_MASK_ALL;
          bf_all_o  <= (dval_q == `COFD_MASK_ALL);
        end
        // both multi-bit shifts share the arithmetic path
        COFD_OP_MULTIBIT_LOGICAL_SHIFT, COFD_OP_MULTIBIT_ARITH_SHIFT: begin
          ex_op_o   <= COFD_EX_MULTIBIT_ARITH_SHIFT;
          illegal_o <= !shift_pair_ok(src1_q, src2_q, dst_q);
          wr_en_o   <= shift_pair_ok(src1_q, src2_q, dst_q);
          cc_upd_o  <= 1'b1;
          wr_data_o <= s1val_q << s2val_q[`COFD_SHAMT_W-1:0];
        end
        // single shift: data registers take the logical path
        COFD_OP_ASL1: begin
          cc_upd_o <= 1'b1;
          if (is_dd(dst_q)) begin
            ex_op_o    <= COFD_EX_LSL1;
            cc_logic_o <= 1'b1;
            wr_en_o    <= 1'b1;
            wr_data_o  <= {dval_q[`COFD_WORD_W-2:0], 1'b0};
          end else if (is_acc(dst_q)) begin
            ex_op_o <= COFD_EX_ASL1;
          end else begin
            illegal_o <= 1'b1;
          end
        end
        // clears: accumulators go to the alu, words get a zero move
        COFD_OP_ZERO: begin
          if (is_acc(dst_q)) begin
            ex_op_o   <= COFD_EX_NONE;
            acc_clr_o <= 1'b1;
            cc_upd_o  <= 1'b1;
          end else if (is_word16(dst_q)) begin
            ex_op_o   <= COFD_EX_MOVE;
            wr_en_o   <= 1'b1;
            wr_data_o <= `COFD_ZERO_WORD;
          end else begin
            illegal_o <= 1'b1;
          end
        end
        // named pull: stack word read one cycle earlier
        COFD_OP_PULL: begin
          ex_op_o   <= COFD_EX_MOVE;
          wr_en_o   <= 1'b1;
          wr_data_o <= mem_rdata_i;
        end
        // unnamed pull: pointer update only, no data
        COFD_OP_PULL_NONE: begin
          ex_op_o <= COFD_EX_NONE;
        end
        default: begin
          ex_op_o <= COFD_EX_NONE;
        end
      endcase
    end else begin
      done_o    <= 1'b0;
      wr_en_o   <= 1'b0;
      acc_clr_o <= 1'b0;
      cc_upd_o  <= 1'b0;
    end
  end

  // registered operand set lookup
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chk_member_o <= 1'b0;
    end else begin
      chk_member_o <= member;
    end
  end
endmodule

// >>> tb/cofd_stack_mem.sv
`timescale 1ns/1ps
// stack memory behind the decoder's pull reads
module cofd_stack_mem (
  input  wire logic        sys_clk_i,
  input  wire logic        mem_rd_i,
  input  wire logic [15:0] mem_addr_i,
  output logic      [15:0] mem_rdata_o = 16'h0000
);
  // word shown for one cycle, zero wait states, then a changing pattern
  always_ff @(posedge sys_clk_i) begin
    if (mem_rd_i) begin
      mem_rdata_o <= mem_addr_i ^ 16'h5A3C;
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

// >>> tb/cofd_decode_chk.sv
`timescale 1ns/1ps
// port-level checks on the operand decoder
module cofd_decode_chk #(
  parameter int OSC_PER_IC = 2
) (
  input wire logic                sys_clk_i,
  input wire logic                rstn_i,
  input wire cofd_pkg::cofd_set_t chk_set_i,
  input wire cofd_pkg::cofd_reg_t chk_reg_i,
  input wire logic                ic_en_o,
  input wire logic                done_o,
  input wire cofd_pkg::cofd_ex_t  ex_op_o,
  input wire logic                illegal_o,
  input wire logic                wr_en_o,
  input wire logic                acc_clr_o,
  input wire logic                cc_upd_o,
  input wire logic                cc_logic_o,
  input wire logic [15:0]         mem_addr_o,
  input wire logic                mem_rd_o,
  input wire logic [15:0]         sp_o,
  input wire logic                chk_member_o
);
  import cofd_pkg::*;
  int          gap_q;
  logic        seen_q;
  logic [15:0] sp_at_rd_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // cycles since the last instruction-cycle pulse
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_q  <= 0;
      seen_q <= 1'b0;
    end else if (ic_en_o) begin
      gap_q  <= 0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 1;
    end
  end
  // stack pointer seen at the pull read
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_at_rd_q <= 16'h0000;
    end else if (mem_rd_o) begin
      sp_at_rd_q <= sp_o;
    end
  end
  AST_IC_PERIOD: assert property (seen_q |-> ic_en_o == (gap_q == OSC_PER_IC - 1))
    else $error("instruction cycle pulse spacing wrong");
  AST_ILLEGAL_NOWR: assert property (illegal_o |-> !wr_en_o && !acc_clr_o)
    else $error("refused operands still wrote");
  AST_LSL_CC: assert property (done_o && ex_op_o == COFD_EX_LSL1 |-> cc_logic_o && wr_en_o)
    else $error("logical shift without logical codes");
  AST_ASL_ACC: assert property (done_o && ex_op_o == COFD_EX_ASL1 |-> !wr_en_o && !cc_logic_o)
    else $error("accumulator shift treated as logical");
  AST_ZERO_NOCC: assert property (wr_en_o && ex_op_o == COFD_EX_MOVE |-> !cc_upd_o)
    else $error("move touched condition codes");
  AST_ACC_CLR: assert property (acc_clr_o |-> cc_upd_o && !wr_en_o && done_o)
    else $error("accumulator clear not a data alu operation");
  AST_PULL_SEQ: assert property (mem_rd_o |-> mem_addr_o == sp_o ##1 !mem_rd_o
    ##[0:2] (wr_en_o && sp_o == sp_at_rd_q - 16'h0001))
    else $error("pull read or decrement wrong");
  AST_SP_STEP: assert property (!$stable(sp_o) |-> sp_o == $past(sp_o) - 16'h0001)
    else $error("stack pointer moved by other than one down");
  AST_IDX_ONLY_N: assert property (chk_set_i == COFD_SET_IDX |=>
    chk_member_o == ($past(chk_reg_i) == COFD_R_N))
    else $error("index field membership wrong");
  AST_PTR_SET: assert property (chk_set_i == COFD_SET_PTR |=>
    chk_member_o == ($past(chk_reg_i) inside {COFD_R_R0, COFD_R_R1, COFD_R_R2, COFD_R_R3}))
    else $error("pointer field membership wrong");
  AST_WR_DONE: assert property (wr_en_o |-> done_o)
    else $error("write-back apart from completion");
  COV_PULL: cover property (mem_rd_o);
  COV_ACC_CLR: cover property (acc_clr_o);
  COV_ILLEGAL: cover property (illegal_o);
  COV_LSL: cover property (cc_logic_o);
endmodule
bind cofd_decode cofd_decode_chk #(.OSC_PER_IC(OSC_PER_IC)) i_chk (.sys_clk_i, .rstn_i, .chk_set_i,
  .chk_reg_i, .ic_en_o, .done_o, .ex_op_o, .illegal_o, .wr_en_o, .acc_clr_o, .cc_upd_o, .cc_logic_o,
  .mem_addr_o, .mem_rd_o, .sp_o, .chk_member_o);

// >>> tb/core_operand_field_decode_tb.sv
`timescale 1ns/1ps
module core_operand_field_decode_tb;
  import cofd_pkg::*;
  typedef struct packed {
    cofd_ex_t    ex;
    logic        ill;
    logic        wr;
    cofd_reg_t   rg;
    logic [15:0] dat;
    logic        ac;
    logic        cc;
    logic        lg;
    logic        sat;
    logic        bf;
    logic [1:0]  ign;
  } cofd_exp_t;
  logic        sys_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        insn_valid_i = 1'b0;
  logic        acc_sat_sel_i = 1'b0;
  cofd_op_t    op_i = COFD_OP_NOP;
  cofd_reg_t   dst_i = COFD_R_A;
  cofd_reg_t   src1_i = COFD_R_A;
  cofd_reg_t   src2_i = COFD_R_A;
  cofd_reg_t   chk_reg_i = COFD_R_A;
  cofd_set_t   chk_set_i = COFD_SET_DATA;
  logic [15:0] imm_i = 16'h0000;
  logic [15:0] dst_val_i = 16'h0000;
  logic [15:0] src1_val_i = 16'h0000;
  logic [15:0] src2_val_i = 16'h0000;
  logic [15:0] mem_rdata_i, wr_data_o, mem_addr_o, sp_o, v, sp_m, m;
  logic        ic_en_o, busy_o, done_o, illegal_o, wr_en_o, acc_clr_o, cc_upd_o, cc_logic_o;
  logic        bf_all_o, mem_rd_o, acc_sat_o, chk_member_o, ok;
  cofd_ex_t    ex_op_o, x;
  cofd_reg_t   wr_reg_o, d;
  cofd_exp_t   e, g;
  cofd_exp_t   q[$];
  int          errors = 0;
  int          cmp_count = 0;
  int          seed = 28912;
  int          k, p;
  cofd_reg_t   pv[9] = '{COFD_R_Y1, COFD_R_Y0, COFD_R_Y1, COFD_R_Y0, COFD_R_A1, COFD_R_B1,
                         COFD_R_X0, COFD_R_A1, COFD_R_B1};
  cofd_reg_t   pa[9] = '{COFD_R_X0, COFD_R_X0, COFD_R_Y0, COFD_R_Y0, COFD_R_Y0, COFD_R_Y1,
                         COFD_R_X0, COFD_R_Y1, COFD_R_Y0};
  logic [14:0] mset[11] = '{15'h007F, 15'h0FFF, 15'h1780, 15'h0780, 15'h0800, 15'h2000,
                            15'h0073, 15'h007C, 15'h0070, 15'h0003, 15'h000C};

  // 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;

  cofd_decode #(.OSC_PER_IC(2)) i_dut (.sys_clk_i, .rstn_i, .insn_valid_i, .op_i, .dst_i, .src1_i,
    .src2_i, .imm_i, .dst_val_i, .src1_val_i, .src2_val_i, .mem_rdata_i, .acc_sat_sel_i, .chk_set_i,
    .chk_reg_i, .ic_en_o, .busy_o, .done_o, .ex_op_o, .illegal_o, .wr_reg_o, .wr_en_o, .wr_data_o,
    .acc_clr_o, .cc_upd_o, .cc_logic_o, .bf_all_o, .mem_addr_o, .mem_rd_o, .sp_o, .acc_sat_o,
    .chk_member_o);

  cofd_stack_mem i_mem (.sys_clk_i, .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i));

  function automatic logic [15:0] rnd();
    return 16'($random(seed));
  endfunction

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // offer one instruction, note its result, wait for completion
  task automatic issue(input cofd_op_t op, input cofd_reg_t dr, input cofd_exp_t ex);
    op_i = op;
    dst_i = dr;
    acc_sat_sel_i = ex.sat;
    insn_valid_i = 1'b1;
    q.push_back(ex);
    for (int i = 0; i < 9 && busy_o !== 1'b1; i++) @(negedge sys_clk_i);
    insn_valid_i = 1'b0;
    for (int i = 0; i < 9 && done_o !== 1'b1; i++) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  task automatic results();
    if (q.size() != 0) errors++;
    $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // compare each finished instruction with the oldest note
  always @(negedge sys_clk_i) begin
    if (done_o === 1'b1) begin
      if (q.size() > 0) e = q.pop_front();
      else e = '1;
      g = {ex_op_o, illegal_o, wr_en_o, wr_reg_o, wr_data_o, acc_clr_o, cc_upd_o, cc_logic_o, acc_sat_o,
           bf_all_o, e.ign};
      if (!e.wr) begin
        g.rg = e.rg;
        g.dat = e.dat;
      end
      if (e.ign[1]) g.ex = e.ex;
      if (e.ign[0]) g.cc = e.cc;
      check(g, e);
    end
  end

  // hang guard
  initial begin
    #100000;
    errors++;
    results();
  end

  initial begin
    repeat (12) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    check(sp_o, 16'h0000);
    // immediate logic aliases and bit-field operations, byte and full masks first
    for (int n = 0; n < 28; n++) begin
      k = 1 + n % 7;
      d = (n % 3 != 0) ? COFD_R_X0 : COFD_R_MEM;
      imm_i = n < 7 ? 16'h00FF : n < 14 ? 16'hFFFF : rnd();
      dst_val_i = rnd();
      v = (k == 1) ? dst_val_i & imm_i : (k == 5) ? dst_val_i & ~imm_i : (k % 4 == 2) ? dst_val_i | imm_i :
          (k == 4) ? ~dst_val_i : dst_val_i ^ imm_i;
      x = (k == 1 || k == 5) ? COFD_EX_BITFIELD_CLEAR_TEST : (k % 4 == 2) ? COFD_EX_BITFIELD_SET_TEST : COFD_EX_BFTGL;
      m = (k == 1) ? ~imm_i : (k == 4) ? 16'hFFFF : imm_i;
      issue(cofd_op_t'(k), d, '{x, 0, 1, d, v, 0, 0, 0, n[0], (dst_val_i & m) == m, 2'b01});
    end
    $display("test bitfield done");
    // multi-bit shifts: listed pairs, refused pairs and a bad destination
    for (int n = 0; n < 15; n++) begin
      p = n < 9 ? n : n - 9;
      src1_i = pv[p];
      src2_i = pa[p];
      d = (n == 5) ? COFD_R_A : cofd_reg_t'(4 + n % 3);
      ok = p < 6 && n != 5;
      src1_val_i = rnd();
      src2_val_i = (pv[p] == pa[p]) ? src1_val_i : rnd();
      issue(n < 9 ? COFD_OP_MULTIBIT_LOGICAL_SHIFT : COFD_OP_MULTIBIT_ARITH_SHIFT, d, '{COFD_EX_MULTIBIT_ARITH_SHIFT, !ok, ok, d,
            src1_val_i << src2_val_i[3:0], 0, 0, 0, n[0], 0, ok ? 2'b01 : 2'b11});
    end
    $display("test multishift done");
    // single shifts on data registers then accumulators
    for (int n = 0; n < 5; n++) begin
      d = cofd_reg_t'(n < 3 ? 4 + n : n - 3);
      ok = n < 3;
      dst_val_i = rnd();
      issue(COFD_OP_ASL1, d, '{ok ? COFD_EX_LSL1 : COFD_EX_ASL1, 0, ok, d, dst_val_i << 1, 0, 0, ok,
            n[0], 0, 2'b01});
    end
    $display("test singleshift done");
    // clears of every 16-bit register a zero move may name, then both accumulators
    for (int n = 2; n < 14; n++) begin
      d = cofd_reg_t'(n < 12 ? n : n - 12);
      ok = n < 12;
      dst_val_i = rnd() | 16'h0001;
      issue(COFD_OP_ZERO, d, '{COFD_EX_MOVE, 0, ok, d, 16'h0000, !ok, !ok, 0, n[0], 0, ok ? 2'b00 : 2'b10});
    end
    $display("test clear done");
    // stack pulls, one without destination, reset in mid-run
    sp_m = 16'h0000;
    for (int n = 0; n < 5; n++) begin
      if (n == 3) begin
        rstn_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        check({busy_o, done_o, sp_o}, 18'h00000);
        rstn_i = 1'b1;
        sp_m = 16'h0000;
      end
      d = (n == 1) ? COFD_R_N : COFD_R_Y1;
      ok = n != 2;
      issue(ok ? COFD_OP_PULL : COFD_OP_PULL_NONE, d, '{COFD_EX_MOVE, 0, ok, d, sp_m ^ 16'h5A3C, 0, 0, 0,
            n[0], 0, ok ? 2'b01 : 2'b11});
      sp_m = sp_m - 16'h0001;
      check(sp_o, sp_m);
    end
    $display("test pull done");
    // every operand field against every register
    for (int n = 0; n < 165; n++) begin
      chk_set_i = cofd_set_t'(n / 15);
      chk_reg_i = cofd_reg_t'(n % 15);
      @(negedge sys_clk_i);
      check(chk_member_o, mset[n / 15][n % 15]);
    end
    $display("test fields done");
    results();
  end
endmodule
